// file: design/sea_array_access.v
`timescale 1ns/1ns
`include "sea_map.vh"
// How it works
// [R01] read: select low, opcode and address in, then byte at that address out
// [R02] while selected, address increments after each output byte
// [R03] sequential read wraps from the top address to zero
// [R04] raising select ends a read at any point; output stops
// [R05] read may start at any byte, no alignment
// [R06] read opcode received during a write cycle is ignored
// [R07] top two address bits are don't-care for read and write
// [R08] write: opcode, address, data; select rise at byte boundary starts timed cycle
// [R09] further data bytes while selected all go into one write cycle
// [R10] data bytes advance only the in-page address, wrapping within 64 bytes
// [R11] write rejected unless the write enable latch was set first
// [R12] write rejected if a write cycle is still running
// [R13] write executes only if select rises right after a full data byte
// [R14] write rejected if the page lies in the protected region
// [R15] six check bits per 4-byte word; single bit errors corrected on read
// [R16] writing a byte reprograms its whole word plus check bits
// [R17] master should write aligned groups of four bytes for endurance
// [R18] delivery: array all FFh, lock and protect bits zero
// [R19] input msb first, sampled on rising clock edges after select falls
// [R20] output msb first, changes on falling edges after the read header
// [R21] master uses clock mode 0 or mode 3
// [R22] output released while not selected
// [R23] latch low blocks array writes and status writes
// [R24] status stays readable during a write cycle
// [R25] block protect bits size the protected area
// [R26] read opcode 03h, write opcode 02h, two address bytes high first
// [R27] latch clears when a write cycle completes
module sea_array_access #(
    parameter P_WRITE_CYCLES = `SEA_WRITE_CYCLES
) (
    input wire i_clk_sys,               // 100 MHz system clock
    input wire i_reset,                 // sync reset, high
    input wire i_spi_sck,               // serial clock pin
    input wire i_spi_sel_n,             // device select pin, low active
    input wire i_spi_mosi,              // serial data in pin
    output reg o_spi_miso,              // serial data out pin
    output wire o_spi_miso_oe,          // high while driving data out
    input wire i_write_enable_cmd,      // pulse: write_enable_cmd decoded
    input wire i_status_write,          // pulse: status write requested
    input wire [2:0] i_status_wdata,    // {lock, protect hi, protect lo}
    output wire o_write_busy_flag,      // write cycle running
    output wire o_write_enable_latch_flag, // writes allowed
    output wire o_block_protect_hi,     // protect field msb
    output wire o_block_protect_lo,     // protect field lsb
    output wire o_status_write_lock,    // status write lock bit
    output reg o_write_rejected,        // pulse: write frame refused
    output reg o_ecc_corrected          // pulse: a word was corrected
);
    localparam S_IDLE = 2'h0;
    localparam S_RD = 2'h1;
    localparam S_MG = 2'h2;
    localparam S_WAIT = 2'h3;

    reg [2:0] sck_q;
    reg [2:0] sel_q;
    reg [1:0] mosi_q;
    reg [2:0] bit_cnt_r;
    reg [1:0] byte_idx_r;
    reg [7:0] rx_sh_r;
    reg [5:0] addr_hi_r;
    reg rd_ok_r;
    reg wr_ok_r;
    reg is_wr_r;
    reg got_data_r;
    reg rd_phase_r;
    reg [`SEA_ADDR_BITS-1:0] fetch_addr_r;
    reg [7:0] page_r;
    reg [5:0] wr_ptr_r;
    reg [7:0] page_buf_r [0:`SEA_PAGE_BYTES-1];
    reg [`SEA_PAGE_BYTES-1:0] mask_r;
    reg inflight_r;
    reg [1:0] lane_r;
    reg [2:0] tx_cnt_r;
    reg [7:0] tx_sh_r;
    reg [1:0] state_r;
    reg [3:0] widx_r;
    reg [31:0] wait_cnt_r;
    reg busy_r;
    reg wel_r;
    reg [1:0] bp_r;
    reg lock_r;
    reg [31:0] merged;
    reg any_byte;
    integer k;

    wire selected = ~sel_q[1];
    wire sel_rise = sel_q[1] & ~sel_q[2];
    wire sck_rise = sck_q[1] & ~sck_q[2];
    wire sck_fall = ~sck_q[1] & sck_q[2];
    wire [7:0] rx_byte = {rx_sh_r[6:0], mosi_q[1]};
    wire byte_done = selected && sck_rise && (bit_cnt_r == 3'h7);
    wire [`SEA_CELL_BITS-1:0] mem_rdata;
    wire [5:0] syndrome;
    wire [31:0] corr_word;
    wire issue;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [7:0] buf_out_data;
    wire tx_take;
    wire wr_start;
    wire wr_done;
    wire status_ok;
    wire mem_we;

    // code of data bit i: non-power-of-two values from 3 upward
    function [5:0] fn_code(input integer i);
        integer n;
        integer j;
        begin
            n = 2;
            for (j = 0; j <= i; j = j + 1) begin
                n = n + 1;
                if (n == 4 || n == 8 || n == 16 || n == 32) begin
                    n = n + 1;
                end
            end
            fn_code = n[5:0];
        end
    endfunction

    // hamming check bits over one word
    function [5:0] fn_chk(input [31:0] d);
        integer i;
        begin
            fn_chk = 6'h00;
            for (i = 0; i < 32; i = i + 1) begin
                if (d[i]) begin
                    fn_chk = fn_chk ^ fn_code(i);
                end
            end
        end
    endfunction

    // flip the data bit the syndrome names
    function [31:0] fn_fix(input [31:0] d, input [5:0] syn);
        integer i;
        begin
            fn_fix = d;
            for (i = 0; i < 32; i = i + 1) begin
                if (syn == fn_code(i)) begin
                    fn_fix[i] = ~d[i];
                end
            end
        end
    endfunction

    // protected region by protect field: none, top quarter, top half, all
    function fn_prot(input [7:0] page, input [1:0] bp);
        begin
            case (bp)
                `SEA_BP_QUARTER: fn_prot = (page[7:6] == 2'h3);
                `SEA_BP_HALF: fn_prot = page[7];
                `SEA_BP_ALL: fn_prot = 1'b1;
                default: fn_prot = 1'b0;
            endcase
        end
    endfunction

    // pins are async: two flops before any use
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            sck_q <= 3'h0;
            sel_q <= 3'h7;
            mosi_q <= 2'h0;
        end else begin
            sck_q <= {sck_q[1:0], i_spi_sck};
            sel_q <= {sel_q[1:0], i_spi_sel_n};
            mosi_q <= {mosi_q[0], i_spi_mosi};
        end
    end

    // check bits offset so an erased cell reads valid
    assign syndrome = mem_rdata[37:32] ^ fn_chk(mem_rdata[31:0]) ^ fn_chk(`SEA_ERASED_WORD);
    assign corr_word = fn_fix(mem_rdata[31:0], syndrome); // R15

    // prefetch a byte while the buffer has room
    assign issue = rd_phase_r && selected && buf_in_ready && !inflight_r; // R02

    // input framing: both modes sample on the rise
    always @(posedge i_clk_sys) begin
        if (i_reset || !selected) begin
            bit_cnt_r <= 3'h0;
            byte_idx_r <= `SEA_BYTE_OPCODE;
            rx_sh_r <= 8'h00;
            rd_ok_r <= 1'b0;
            wr_ok_r <= 1'b0;
            is_wr_r <= 1'b0;
            got_data_r <= 1'b0;
            rd_phase_r <= 1'b0; // R04
        end else begin
            if (sck_rise) begin
                rx_sh_r <= rx_byte; // R19 R21
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            if (byte_done) begin
                if (byte_idx_r != `SEA_BYTE_DATA) begin
                    byte_idx_r <= byte_idx_r + 2'h1;
                end
                case (byte_idx_r)
                    `SEA_BYTE_OPCODE: begin
                        rd_ok_r <= (rx_byte == `SEA_OP_READ) && !busy_r; // R26 R06
                        wr_ok_r <= (rx_byte == `SEA_OP_WRITE) && !busy_r && wel_r; // R11 R12 R23
                        is_wr_r <= (rx_byte == `SEA_OP_WRITE);
                    end
                    `SEA_BYTE_ADDR_HI: begin
                        addr_hi_r <= rx_byte[5:0]; // R07
                    end
                    `SEA_BYTE_ADDR_LO: begin
                        rd_phase_r <= rd_ok_r; // R01
                        fetch_addr_r <= {addr_hi_r, rx_byte}; // R05
                        if (wr_ok_r) begin
                            page_r <= {addr_hi_r, rx_byte[7:6]};
                            wr_ptr_r <= rx_byte[5:0];
                            mask_r <= {`SEA_PAGE_BYTES{1'b0}};
                        end
                    end
                    default: begin
                        got_data_r <= 1'b1;
                        // a refused frame must not spoil a page still being programmed
                        if (wr_ok_r) begin
                            page_buf_r[wr_ptr_r] <= rx_byte; // R09
                            mask_r[wr_ptr_r] <= 1'b1;
                            wr_ptr_r <= wr_ptr_r + 6'h01; // R10
                        end
                    end
                endcase
            end
            if (issue) begin
                fetch_addr_r <= fetch_addr_r + 14'h0001; // R02 R03
            end
        end
    end

    // read pipeline: array answers one cycle after the address
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            inflight_r <= 1'b0;
            lane_r <= 2'h0;
            o_ecc_corrected <= 1'b0;
        end else begin
            inflight_r <= issue;
            if (issue) begin
                lane_r <= fetch_addr_r[1:0];
            end
            o_ecc_corrected <= (inflight_r || state_r == S_MG) && (syndrome != 6'h00); // R15
        end
    end

    sea_pair_buffer #(
        .P_WIDTH(8),
        .P_DEPTH(2),
        .P_AW(1)
    ) u_buf (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_flush(!selected),
        .i_in_valid(inflight_r && rd_phase_r && selected),
        .o_in_ready(buf_in_ready),
        .i_in_data(corr_word[lane_r*8 +: 8]),
        .o_out_valid(buf_out_valid),
        .i_out_ready(tx_take),
        .o_out_data(buf_out_data)
    );

    // output shifter: new byte taken on the first fall of each byte
    assign tx_take = selected && rd_phase_r && sck_fall && (tx_cnt_r == 3'h0);
    assign o_spi_miso_oe = selected && rd_phase_r; // R22 R04

    always @(posedge i_clk_sys) begin
        if (i_reset || !selected) begin
            tx_cnt_r <= 3'h0;
            tx_sh_r <= 8'h00;
            o_spi_miso <= 1'b0;
        end else if (rd_phase_r && sck_fall) begin
            tx_cnt_r <= tx_cnt_r + 3'h1;
            if (tx_cnt_r == 3'h0) begin
                // an underrun sends a zero msb then stale buffer bits; not reachable at the link's rated clock
                o_spi_miso <= buf_out_valid & buf_out_data[7]; // R20
                tx_sh_r <= {buf_out_data[6:0], 1'b0};
            end else begin
                o_spi_miso <= tx_sh_r[7]; // R20
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
        end
    end

    // deselect must land on a byte boundary after a data byte
    assign wr_start = sel_rise && wr_ok_r && got_data_r && (bit_cnt_r == 3'h0)
        && !fn_prot(page_r, bp_r); // R08 R13 R14 R25

    // refusal is only reported once an opcode has been seen
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_write_rejected <= 1'b0;
        end else begin
            o_write_rejected <= sel_rise && is_wr_r && !wr_start; // R11 R12 R13 R14
        end
    end

    // merge loaded bytes into the corrected old word
    always @* begin
        merged = corr_word;
        any_byte = 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            if (mask_r[widx_r*4 + k]) begin
                merged[k*8 +: 8] = page_buf_r[widx_r*4 + k]; // R16
                any_byte = 1'b1;
            end
        end
    end

    assign mem_we = (state_r == S_MG) && any_byte; // R16

    sea_word_mem #(
        .P_WIDTH(`SEA_CELL_BITS),
        .P_DEPTH(`SEA_WORDS),
        .P_AW(`SEA_WORD_ADDR_BITS),
        .P_INIT(`SEA_ERASED_CELL)
    ) u_mem (
        .i_clk_sys(i_clk_sys),
        .i_addr(busy_r ? {page_r, widx_r} : fetch_addr_r[13:2]),
        .i_we(mem_we),
        .i_wdata({fn_chk(merged) ^ fn_chk(`SEA_ERASED_WORD), merged}), // R15 R18
        .o_rdata(mem_rdata)
    );

    // self-timed write: program touched words, then wait
    assign wr_done = (state_r == S_WAIT) && (wait_cnt_r == P_WRITE_CYCLES - 1);

    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= S_IDLE;
            widx_r <= 4'h0;
            wait_cnt_r <= 32'h0;
            busy_r <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (wr_start) begin
                        state_r <= S_RD;
                        widx_r <= 4'h0;
                        busy_r <= 1'b1; // R08
                    end
                end
                S_RD: begin
                    state_r <= S_MG;
                end
                S_MG: begin
                    widx_r <= widx_r + 4'h1;
                    wait_cnt_r <= 32'h0;
                    state_r <= (widx_r == 4'hF) ? S_WAIT : S_RD; // R09
                end
                S_WAIT: begin
                    wait_cnt_r <= wait_cnt_r + 32'h1;
                    if (wr_done) begin
                        state_r <= S_IDLE;
                        busy_r <= 1'b0; // R08
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // status bits stay visible, busy or not
    assign status_ok = i_status_write && wel_r && !busy_r; // R23

    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            wel_r <= 1'b0;
            bp_r <= 2'h0; // R18
            lock_r <= 1'b0; // R18
        end else begin
            if (i_write_enable_cmd) begin
                wel_r <= 1'b1; // set wins over any clear
            end else if (wr_done || status_ok) begin
                wel_r <= 1'b0; // R27
            end
            if (status_ok) begin
                lock_r <= i_status_wdata[2];
                bp_r <= i_status_wdata[1:0]; // R25
            end
        end
    end

    assign o_write_busy_flag = busy_r; // R24
    assign o_write_enable_latch_flag = wel_r;
    assign o_block_protect_hi = bp_r[1];
    assign o_block_protect_lo = bp_r[0];
    assign o_status_write_lock = lock_r;
endmodule // sea_array_access

// file: common/sea_map.vh
`ifndef SEA_MAP_VH
`define SEA_MAP_VH
// instruction codes
`define SEA_OP_READ 8'h03
`define SEA_OP_WRITE 8'h02
// array geometry
`define SEA_ADDR_BITS 14
`define SEA_WORD_ADDR_BITS 12
`define SEA_WORDS 4096
`define SEA_PAGE_BYTES 64
`define SEA_CELL_BITS 38
`define SEA_ERASED_WORD 32'hFFFFFFFF
`define SEA_ERASED_CELL 38'h00FFFFFFFF
// frame byte positions
`define SEA_BYTE_OPCODE 2'h0
`define SEA_BYTE_ADDR_HI 2'h1
`define SEA_BYTE_ADDR_LO 2'h2
`define SEA_BYTE_DATA 2'h3
// block protect field codes
`define SEA_BP_NONE 2'h0
`define SEA_BP_QUARTER 2'h1
`define SEA_BP_HALF 2'h2
`define SEA_BP_ALL 2'h3
// timing
`define SEA_CLK_PERIOD_NS 10
`define SEA_WRITE_CYCLE_TIME_NS 1000000
`define SEA_WRITE_CYCLES (`SEA_WRITE_CYCLE_TIME_NS / `SEA_CLK_PERIOD_NS)
`endif

// file: design/sea_word_mem.v
`timescale 1ns/1ns
`include "sea_map.vh"
// single-port array of code words, read data registered
module sea_word_mem #(
    parameter P_WIDTH = `SEA_CELL_BITS,
    parameter P_DEPTH = `SEA_WORDS,
    parameter P_AW = `SEA_WORD_ADDR_BITS,
    parameter [P_WIDTH-1:0] P_INIT = `SEA_ERASED_CELL
) (
    input wire i_clk_sys,              // system clock
    input wire [P_AW-1:0] i_addr,      // word address
    input wire i_we,                   // write strobe
    input wire [P_WIDTH-1:0] i_wdata,  // word to store
    output reg [P_WIDTH-1:0] o_rdata   // word at last cycle's address
);
    reg [P_WIDTH-1:0] mem [0:P_DEPTH-1];
    integer i;

    // erased at power-on; no reset, the array is non-volatile
    initial begin
        for (i = 0; i < P_DEPTH; i = i + 1) begin
            mem[i] = P_INIT;
        end
    end

    // read-before-write on the same port
    always @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule // sea_word_mem

// file: design/sea_pair_buffer.v
`timescale 1ns/1ns
// small fifo between array prefetch and serial shifter
module sea_pair_buffer #(
    parameter P_WIDTH = 8,
    parameter P_DEPTH = 2,
    parameter P_AW = 1
) (
    input wire i_clk_sys,              // system clock
    input wire i_reset,                // sync reset, high
    input wire i_flush,                // drop all entries
    input wire i_in_valid,             // producer has a word
    output wire o_in_ready,            // room for a word
    input wire [P_WIDTH-1:0] i_in_data,// producer word
    output wire o_out_valid,           // a word is waiting
    input wire i_out_ready,            // consumer takes it
    output wire [P_WIDTH-1:0] o_out_data // oldest word
);
    reg [P_WIDTH-1:0] mem [0:P_DEPTH-1];
    reg [P_AW-1:0] wp_r;
    reg [P_AW-1:0] rp_r;
    reg [P_AW:0] count_r;
    wire push;
    wire pop;

    function [P_AW-1:0] fn_next(input [P_AW-1:0] p);
        begin
            if (p == P_DEPTH - 1) begin
                fn_next = {P_AW{1'b0}};
            end else begin
                fn_next = p + 1'b1;
            end
        end
    endfunction

    assign o_in_ready = (count_r != P_DEPTH);
    assign o_out_valid = (count_r != 0);
    assign o_out_data = mem[rp_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    // pointers and fill level; flush beats any push in the same cycle
    always @(posedge i_clk_sys) begin
        if (i_reset || i_flush) begin
            wp_r <= {P_AW{1'b0}};
            rp_r <= {P_AW{1'b0}};
            count_r <= {(P_AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wp_r] <= i_in_data;
                wp_r <= fn_next(wp_r);
            end
            if (pop) begin
                rp_r <= fn_next(rp_r);
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // sea_pair_buffer

// file: verif/sea_array_access_sva.sv
`timescale 1ns/1ns
// protocol watcher for the array access block
module sea_array_access_sva #(
    parameter P_WRITE_CYCLES = 20
) (
    input wire i_clk_sys, // clock
    input wire i_reset, // sync reset
    input wire i_spi_sck, // serial clock
    input wire i_spi_sel_n, // select
    input wire o_spi_miso, // data out
    input wire o_spi_miso_oe, // out enable
    input wire i_write_enable_cmd, // latch set
    input wire i_status_write, // status load
    input wire [2:0] i_status_wdata, // status bits
    input wire o_write_busy_flag, // busy
    input wire o_write_enable_latch_flag, // latch
    input wire o_block_protect_hi, // protect msb
    input wire o_block_protect_lo, // protect lsb
    input wire o_status_write_lock, // lock
    input wire o_write_rejected // refused
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    reg [15:0] busy_cnt_r;
    // cleared while idle, each cycle timed alone
    always @(posedge i_clk_sys) begin
        if (i_reset || !o_write_busy_flag) begin
            busy_cnt_r <= 16'h0000;
        end else begin
            busy_cnt_r <= busy_cnt_r + 16'h0001;
        end
    end
    // select high long enough to pass the synchronisers
    sequence s_idle;
        i_spi_sel_n [*5];
    endsequence
    sequence s_take;
        i_status_write && o_write_enable_latch_flag && !o_write_busy_flag && !i_write_enable_cmd;
    endsequence
    out_released_a: assert property (s_idle |-> !o_spi_miso_oe)
        else $error("data out driven while deselected");
    out_on_fall_a: assert property (o_spi_miso_oe && $past(o_spi_miso_oe) && $changed(o_spi_miso)
        |-> !i_spi_sck && !$past(i_spi_sck, 2))
        else $error("data out changed away from a clock fall");
    read_busy_a: assert property ($rose(o_spi_miso_oe) |-> !$past(o_write_busy_flag))
        else $error("read answered during a write cycle");
    reject_sel_a: assert property (o_write_rejected |-> i_spi_sel_n && $past(i_spi_sel_n, 2))
        else $error("refusal without deselect");
    busy_start_a: assert property ($rose(o_write_busy_flag)
        |-> $past(o_write_enable_latch_flag) && i_spi_sel_n && !o_write_rejected)
        else $error("write cycle started without latch or select rise");
    busy_end_a: assert property ($fell(o_write_busy_flag) |-> !o_write_enable_latch_flag)
        else $error("latch still set after write cycle");
    busy_len_a: assert property ($fell(o_write_busy_flag)
        |-> busy_cnt_r >= P_WRITE_CYCLES + 30 && busy_cnt_r <= P_WRITE_CYCLES + 32)
        else $error("write cycle length wrong");
    status_load_a: assert property (s_take |=> {o_status_write_lock, o_block_protect_hi,
        o_block_protect_lo} == $past(i_status_wdata) && !o_write_enable_latch_flag)
        else $error("status bits not loaded");
    status_keep_a: assert property (i_status_write && !o_write_enable_latch_flag
        |=> $stable({o_status_write_lock, o_block_protect_hi, o_block_protect_lo}))
        else $error("status bits changed without latch");
endmodule // sea_array_access_sva
bind sea_array_access sea_array_access_sva #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) sea_array_access_sva_i (.*);

// file: verif/sea_spi_host.sv
`timescale 1ns/1ns
// behavioural bus master, mode 0 or mode 3, 125 ns bit time
module sea_spi_host (
    output reg o_sck, // serial clock
    output reg o_sel_n, // device select
    output reg o_mosi, // data to device
    input wire i_miso, // data from device
    input wire i_miso_oe // device drives data
);
    reg cpol = 1'b0; // idle clock level, 1 for mode 3
    reg last_r = 1'b0;
    // a released line reads back inverted
    wire line = i_miso_oe ? i_miso : ~last_r;
    initial begin
        o_sck = 1'b0;
        o_sel_n = 1'b1;
        o_mosi = 1'b0;
    end
    task automatic begin_frame;
        o_sck = cpol;
        #40 o_sel_n = 1'b0;
        #40;
    endtask
    // msb first; data set after the fall, taken at the rise
    task automatic xfer(input [7:0] tx, input int nbits, output [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            o_sck = 1'b0;
            o_mosi = tx[7 - i];
            #62 o_sck = 1'b1;
            rx = {rx[6:0], line};
            last_r = line;
            #63;
        end
    endtask
    // select rises before the next rise, clock then idle
    task automatic end_frame;
        o_sck = cpol;
        #63 o_sel_n = 1'b1;
        #80;
    endtask
endmodule // sea_spi_host

// file: verif/sea_array_access_tb_top.sv
`timescale 1ns/1ns
`include "sea_map.vh"
module sea_array_access_tb_top;
    localparam int WC = 2000; // long enough to send two frames inside a cycle
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg wen = 1'b0;
    reg st_wr = 1'b0;
    reg [2:0] st_wd = 3'h0;
    wire sck, sel_n, mosi, miso, oe, busy, latch, bp_hi, bp_lo, lock, rej, ecc;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    reg rej_seen = 1'b0;
    reg busy_seen = 1'b0;
    reg oe_seen = 1'b0;
    reg ecc_seen = 1'b0;
    reg [31:0] got;
    sea_array_access #(.P_WRITE_CYCLES(WC)) sea_array_access_i (
        .i_clk_sys(clk), .i_reset(reset), .i_spi_sck(sck), .i_spi_sel_n(sel_n),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe),
        .i_write_enable_cmd(wen), .i_status_write(st_wr), .i_status_wdata(st_wd),
        .o_write_busy_flag(busy), .o_write_enable_latch_flag(latch),
        .o_block_protect_hi(bp_hi), .o_block_protect_lo(bp_lo),
        .o_status_write_lock(lock), .o_write_rejected(rej), .o_ecc_corrected(ecc));
    sea_spi_host host (.o_sck(sck), .o_sel_n(sel_n), .o_mosi(mosi), .i_miso(miso),
        .i_miso_oe(oe));
    initial begin
        forever #5 clk = ~clk;
    end
    // sticky pulse copies, hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rej === 1'b1) rej_seen <= 1'b1;
        if (busy === 1'b1) busy_seen <= 1'b1;
        if (oe === 1'b1) oe_seen <= 1'b1;
        if (ecc === 1'b1) ecc_seen <= 1'b1;
        if (cyc == 40000) begin
            fails++;
            test_done;
        end
    end
    task automatic test_done;
        $display("TB: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input [31:0] exp, input [31:0] seen);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic clr;
        @(negedge clk);
        {rej_seen, busy_seen, oe_seen, ecc_seen} = 4'h0;
    endtask
    // opcode, address, n data bytes, then tail bits of a cut byte
    task automatic frame(input [7:0] op, input [15:0] a, input int n, input [31:0] d,
        input int tail);
        reg [7:0] rx;
        host.begin_frame();
        host.xfer(op, 8, rx);
        host.xfer(a[15:8], 8, rx);
        host.xfer(a[7:0], 8, rx);
        got = 32'h0;
        for (int i = 0; i < n; i++) begin
            host.xfer(d[31 - 8 * i -: 8], 8, rx);
            got = {got[23:0], rx};
        end
        if (tail > 0) host.xfer(8'hAA, tail, rx);
        host.end_frame();
    endtask
    task automatic set_wen;
        @(negedge clk) wen = 1'b1;
        @(negedge clk) wen = 1'b0;
    endtask
    task automatic stat(input [2:0] v);
        @(negedge clk) st_wr = 1'b1;
        st_wd = v;
        @(negedge clk) st_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < WC + 100 && busy !== 1'b0; i++) @(negedge clk);
        chk("cycle end", 0, busy);
    endtask
    task automatic t_delivery;
        chk("status", 0, {lock, bp_hi, bp_lo, latch, busy});
        frame(`SEA_OP_READ, 16'hC000, 3, 0, 0);
        chk("erased", 32'h00FFFFFF, got);
        chk("released", 0, oe);
        $display("TB: delivery done");
    endtask
    task automatic t_no_latch;
        clr;
        frame(`SEA_OP_WRITE, 16'h0010, 1, 32'h55000000, 0);
        chk("refused", 1, rej_seen);
        chk("no cycle", 0, busy_seen);
        $display("TB: no latch done");
    endtask
    task automatic t_page;
        set_wen;
        clr;
        frame(`SEA_OP_WRITE, 16'hBFFE, 3, 32'hA1B2C300, 0);
        chk("started", 1, busy_seen);
        wait_idle;
        chk("latch", 0, latch);
        frame(`SEA_OP_READ, 16'h3FFE, 3, 0, 0);
        chk("wrap", 32'h00A1B2FF, got);
        frame(`SEA_OP_READ, 16'h7FC0, 4, 0, 0);
        chk("page wrap", 32'hC3FFFFFF, got);
        $display("TB: page done");
    endtask
    task automatic t_busy;
        set_wen;
        frame(`SEA_OP_WRITE, 16'h0100, 4, 32'h11223344, 0);
        clr;
        frame(`SEA_OP_READ, 16'h0100, 1, 0, 0);
        chk("busy read", 0, oe_seen);
        frame(`SEA_OP_WRITE, 16'h0104, 1, 32'h66000000, 0);
        chk("busy write", 1, rej_seen);
        wait_idle;
        frame(`SEA_OP_READ, 16'h0100, 4, 0, 0);
        chk("bytes", 32'h11223344, got);
        $display("TB: busy done");
    endtask
    task automatic t_protect;
        stat(3'b011);
        chk("no latch", 0, {lock, bp_hi, bp_lo});
        set_wen;
        stat(3'b011);
        chk("loaded", 4'h6, {lock, bp_hi, bp_lo, latch});
        set_wen;
        clr;
        frame(`SEA_OP_WRITE, 16'h0000, 1, 32'h99000000, 0);
        chk("protected", 1, rej_seen);
        set_wen;
        stat(3'b000);
        chk("cleared", 0, {lock, bp_hi, bp_lo});
        $display("TB: protect done");
    endtask
    task automatic t_cut;
        set_wen;
        clr;
        frame(`SEA_OP_WRITE, 16'h0200, 1, 32'h77000000, 4);
        chk("cut refused", 1, rej_seen);
        chk("cut no cycle", 0, busy_seen);
        host.cpol = 1'b1;
        sea_array_access_i.u_mem.mem[0][0] = 1'b0;
        frame(`SEA_OP_READ, 16'h3FFF, 2, 0, 0);
        chk("mode 3", 32'h0000B2FF, got);
        chk("corrected", 1, ecc_seen);
        $display("TB: cut done");
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        t_delivery;
        t_no_latch;
        t_page;
        t_busy;
        t_protect;
        t_cut;
        test_done;
    end
endmodule // sea_array_access_tb_top
